// File: rtl/io_configuration_registers.sv
// io configuration register pair with decoded control outputs
//
// How it works
// - bit7 set: single driver, else differential
// - bit6 picks driver/input pair a or b in single drive; differential always uses a
// - bit5 rx water level 64 or 80
// - bit4 tx water level 32 or 16
// - bit3 crystal 13.56/27.12, resets one
// - bits2:1 pick host clock 3.39/6.78/13.56
// - code 11 holds host clock low
// - slow clock when oscillator stopped, not suppressed
// - defaults only at power-up reset
// - second bit7 selects 3.3 V supply
// - second bit6 disables digital supply regulator
// - bit4: pulldown while selected, output undriven
// - bit3: pulldown while chip select high
// - bit2: stronger serial output drive
// - bit0: slow transmitter ramp at turn-on
`timescale 1ns/1ps
module io_configuration_registers
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wrStrobe,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  input wire logic oscRunning,
  input wire logic slowClock,
  input wire logic chipSelect_n,
  input wire logic serialOutDriven,
  output logic singleDrive,
  output logic altAntennaPairSelect,
  output logic [6:0] rxWaterLevel,
  output logic [6:0] txWaterLevel,
  output logic xtalHighFreq,
  output logic [1:0] hostClockSelect,
  output logic hostClockOut,
  output logic lowSupplyMode,
  output logic digitalSupplyRailOff,
  output logic serialOutPulldown,
  output logic serialOutStrongDrive,
  output logic slowTxRamp
);
  import io_config_pkg::*;

  // ----------------------------------------
  // local names
  // ----------------------------------------
  // slot of each pin in the synchroniser chain
  localparam int SYNC_OSC = 0;
  localparam int SYNC_SLOW = 1;
  localparam int SYNC_CS = 2;
  localparam int SYNC_PINS = 3;
  // idle levels: oscillator stopped, slow clock low, chip select released
  localparam logic [SYNC_PINS-1:0] SYNC_IDLE = 3'h4;

  // register storage and read port
  logic [7:0] antCfg_r;
  logic [7:0] antCfg_nxt;
  logic [7:0] supCfg_r;
  logic [7:0] supCfg_nxt;
  logic [7:0] rdData_nxt;
  // pin synchronisers, one slot per pin
  logic [SYNC_PINS-1:0] pinRaw;
  logic [SYNC_PINS-1:0] pinSync1_r;
  logic [SYNC_PINS-1:0] pinSync2_r;
  logic oscLive;
  logic slowClockLive;
  logic csIdle;
  // host clock divider and pin
  logic [2:0] divCnt_r;
  logic [2:0] divCnt_nxt;
  logic slowClockPath;
  logic hostClockOut_nxt;
  // decoded antenna, fifo and clock controls
  logic singleDrive_nxt;
  logic altPair_nxt;
  logic [6:0] rxLevel_nxt;
  logic [6:0] txLevel_nxt;
  logic xtalHighFreq_nxt;
  logic [1:0] hostClockSelect_nxt;
  // decoded supply and serial pin controls
  logic lowSupply_nxt;
  logic railOff_nxt;
  logic pulldown_nxt;
  logic strongDrive_nxt;
  logic slowRamp_nxt;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // only arst_n (power-up) loads defaults; no soft default command reaches here
  always_comb
  begin
    antCfg_nxt = antCfg_r;
    supCfg_nxt = supCfg_r;
    if (wrStrobe && regAddr == ANTENNA_FIFO_CLOCK_CONFIG_ADDR)
    begin
      antCfg_nxt = wrData;
    end
    // unused bits are never stored, so they cannot leak into a later read
    if (wrStrobe && regAddr == SUPPLY_AND_PIN_CONFIG_ADDR)
    begin
      supCfg_nxt = wrData & SUPPLY_WRITE_MASK;
    end
  end

  // the asynchronous reset stands for power-up; nothing else restores defaults
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      antCfg_r <= ANTENNA_FIFO_CLOCK_RESET;
      supCfg_r <= SUPPLY_AND_PIN_RESET;
    end
    else
    begin
      antCfg_r <= antCfg_nxt;
      supCfg_r <= supCfg_nxt;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // read data leaves the block from a flop, so the host takes it one edge
  // after it presents the address; unmapped addresses read zero
  always_comb
  begin
    rdData_nxt = 8'h00;
    if (regAddr == ANTENNA_FIFO_CLOCK_CONFIG_ADDR)
    begin
      rdData_nxt = antCfg_r;
    end
    else if (regAddr == SUPPLY_AND_PIN_CONFIG_ADDR)
    begin
      rdData_nxt = supCfg_r;
    end
  end

  // read data register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdData <= 8'h00;
    end
    else
    begin
      rdData <= rdData_nxt;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // oscillator status, slow clock and chip select come from other domains
  assign pinRaw = {chipSelect_n, slowClock, oscRunning};

  // two flops per pin; only the second stage is read by any logic
  for (genvar i = 0; i < SYNC_PINS; i++)
  begin : g_sync
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        pinSync1_r[i] <= SYNC_IDLE[i];
        pinSync2_r[i] <= SYNC_IDLE[i];
      end
      else
      begin
        pinSync1_r[i] <= pinRaw[i];
        pinSync2_r[i] <= pinSync1_r[i];
      end
    end
  end

  // settled pin levels for the decode logic
  assign oscLive = pinSync2_r[SYNC_OSC];
  assign slowClockLive = pinSync2_r[SYNC_SLOW];
  assign csIdle = pinSync2_r[SYNC_CS];

  // ----------------------------------------
  // host clock divider
  // ----------------------------------------
  // ref_clk stands in for the crystal clock here, so the divided rates are
  // relative; bit 0 halves, bit 1 quarters and bit 2 eighths the reference,
  // which keeps the three codes one octave apart as on the real pin
  always_comb
  begin
    divCnt_nxt = 3'(divCnt_r + 3'h1);
  end

  // free-running divider, never gated, so a code change needs no restart
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      divCnt_r <= 3'h0;
    end
    else
    begin
      divCnt_r <= divCnt_nxt;
    end
  end

  // ----------------------------------------
  // host clock pin
  // ----------------------------------------
  // the slow clock reaches the pin only while the oscillator is stopped,
  // the pin is not disabled and the suppress bit is clear
  always_comb
  begin
    slowClockPath = !oscLive && antCfg_r[HOST_CLK_HI_BIT:HOST_CLK_LO_BIT] != HOST_CLK_OFF
      && !antCfg_r[SLOW_CLK_OFF_BIT];
    hostClockOut_nxt = 1'b0;
    unique case (host_clk_sel_t'(antCfg_r[HOST_CLK_HI_BIT:HOST_CLK_LO_BIT]))
      HOST_CLK_OFF:
      begin
        hostClockOut_nxt = 1'b0;
      end
      HOST_CLK_DIV8:
      begin
        hostClockOut_nxt = oscLive ? divCnt_r[2] : 1'b0;
      end
      HOST_CLK_DIV4:
      begin
        hostClockOut_nxt = oscLive ? divCnt_r[1] : 1'b0;
      end
      HOST_CLK_DIV2:
      begin
        hostClockOut_nxt = oscLive ? divCnt_r[0] : 1'b0;
      end
    endcase
    // with the oscillator stopped the slow clock takes the pin over
    if (slowClockPath)
    begin
      hostClockOut_nxt = slowClockLive;
    end
  end

  // registered so the pin never glitches while the code or the pins change
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hostClockOut <= 1'b0;
    end
    else
    begin
      hostClockOut <= hostClockOut_nxt;
    end
  end

  // ----------------------------------------
  // antenna, fifo and clock decode
  // ----------------------------------------
  // plain field decode of the first register
  always_comb
  begin
    singleDrive_nxt = antCfg_r[SINGLE_DRIVE_BIT];
    // pair b only means something in single drive, so it is gated by it
    altPair_nxt = antCfg_r[SINGLE_DRIVE_BIT] & antCfg_r[ALT_PAIR_BIT];
    rxLevel_nxt = antCfg_r[RX_LEVEL_BIT] ? RX_LEVEL_HIGH : RX_LEVEL_LOW;
    txLevel_nxt = antCfg_r[TX_LEVEL_BIT] ? TX_LEVEL_HIGH : TX_LEVEL_LOW;
    xtalHighFreq_nxt = antCfg_r[XTAL_SEL_BIT];
    hostClockSelect_nxt = antCfg_r[HOST_CLK_HI_BIT:HOST_CLK_LO_BIT];
  end

  // reset values follow the power-up contents of the register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      singleDrive <= ANTENNA_FIFO_CLOCK_RESET[SINGLE_DRIVE_BIT];
      altAntennaPairSelect <= ANTENNA_FIFO_CLOCK_RESET[SINGLE_DRIVE_BIT] & ANTENNA_FIFO_CLOCK_RESET[ALT_PAIR_BIT];
      rxWaterLevel <= ANTENNA_FIFO_CLOCK_RESET[RX_LEVEL_BIT] ? RX_LEVEL_HIGH : RX_LEVEL_LOW;
      txWaterLevel <= ANTENNA_FIFO_CLOCK_RESET[TX_LEVEL_BIT] ? TX_LEVEL_HIGH : TX_LEVEL_LOW;
      xtalHighFreq <= ANTENNA_FIFO_CLOCK_RESET[XTAL_SEL_BIT];
      hostClockSelect <= ANTENNA_FIFO_CLOCK_RESET[HOST_CLK_HI_BIT:HOST_CLK_LO_BIT];
    end
    else
    begin
      singleDrive <= singleDrive_nxt;
      altAntennaPairSelect <= altPair_nxt;
      rxWaterLevel <= rxLevel_nxt;
      txWaterLevel <= txLevel_nxt;
      xtalHighFreq <= xtalHighFreq_nxt;
      hostClockSelect <= hostClockSelect_nxt;
    end
  end

  // ----------------------------------------
  // supply and serial pin decode
  // ----------------------------------------
  // field decode of the second register
  always_comb
  begin
    lowSupply_nxt = supCfg_r[LOW_SUPPLY_BIT];
    railOff_nxt = supCfg_r[RAIL_OFF_BIT];
    strongDrive_nxt = supCfg_r[STRONG_DRIVE_BIT];
    slowRamp_nxt = supCfg_r[SLOW_RAMP_BIT];
    // one pulldown output covers both chip select states
    pulldown_nxt = csIdle ? supCfg_r[IDLE_PULLDOWN_BIT]
      : (supCfg_r[SEL_PULLDOWN_BIT] & ~serialOutDriven);
  end

  // reset values follow the power-up contents, chip select released
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lowSupplyMode <= SUPPLY_AND_PIN_RESET[LOW_SUPPLY_BIT];
      digitalSupplyRailOff <= SUPPLY_AND_PIN_RESET[RAIL_OFF_BIT];
      serialOutPulldown <= SUPPLY_AND_PIN_RESET[IDLE_PULLDOWN_BIT];
      serialOutStrongDrive <= SUPPLY_AND_PIN_RESET[STRONG_DRIVE_BIT];
      slowTxRamp <= SUPPLY_AND_PIN_RESET[SLOW_RAMP_BIT];
    end
    else
    begin
      lowSupplyMode <= lowSupply_nxt;
      digitalSupplyRailOff <= railOff_nxt;
      serialOutPulldown <= pulldown_nxt;
      serialOutStrongDrive <= strongDrive_nxt;
      slowTxRamp <= slowRamp_nxt;
    end
  end
endmodule

// File: rtl/io_config_pkg.sv
// constants for the io configuration register bank
package io_config_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [5:0] ANTENNA_FIFO_CLOCK_CONFIG_ADDR = 6'h00;
  localparam logic [5:0] SUPPLY_AND_PIN_CONFIG_ADDR = 6'h01;

  // ----------------------------------------
  // field positions, first register
  // ----------------------------------------
  localparam int SINGLE_DRIVE_BIT = 7;
  localparam int ALT_PAIR_BIT = 6;
  localparam int RX_LEVEL_BIT = 5;
  localparam int TX_LEVEL_BIT = 4;
  localparam int XTAL_SEL_BIT = 3;
  localparam int HOST_CLK_HI_BIT = 2;
  localparam int HOST_CLK_LO_BIT = 1;
  localparam int SLOW_CLK_OFF_BIT = 0;

  // ----------------------------------------
  // field positions, second register
  // ----------------------------------------
  localparam int LOW_SUPPLY_BIT = 7;
  localparam int RAIL_OFF_BIT = 6;
  localparam int SEL_PULLDOWN_BIT = 4;
  localparam int IDLE_PULLDOWN_BIT = 3;
  localparam int STRONG_DRIVE_BIT = 2;
  localparam int SLOW_RAMP_BIT = 0;
  localparam logic [7:0] SUPPLY_WRITE_MASK = 8'hdd;

  // ----------------------------------------
  // power-up values and water levels
  // ----------------------------------------
  localparam logic [7:0] ANTENNA_FIFO_CLOCK_RESET = 8'h08;
  localparam logic [7:0] SUPPLY_AND_PIN_RESET = 8'h00;
  localparam logic [6:0] RX_LEVEL_LOW = 7'h40;
  localparam logic [6:0] RX_LEVEL_HIGH = 7'h50;
  localparam logic [6:0] TX_LEVEL_LOW = 7'h20;
  localparam logic [6:0] TX_LEVEL_HIGH = 7'h10;

  // host clock divider codes
  typedef enum logic [1:0]
  {
    HOST_CLK_DIV8 = 2'b00,
    HOST_CLK_DIV4 = 2'b01,
    HOST_CLK_DIV2 = 2'b10,
    HOST_CLK_OFF = 2'b11
  } host_clk_sel_t;
endpackage

// File: tb/io_config_props.sv
// checker for the io configuration register bank
`timescale 1ns/1ps
module io_config_props
(
  input logic ref_clk,
  input logic arst_n,
  input logic wrStrobe,
  input logic [5:0] regAddr,
  input logic [7:0] wrData,
  input logic [7:0] rdData,
  input logic singleDrive,
  input logic altAntennaPairSelect,
  input logic xtalHighFreq,
  input logic [1:0] hostClockSelect,
  input logic hostClockOut,
  input logic lowSupplyMode,
  input logic slowTxRamp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // a write lands at its edge, decoded outputs one edge later
  sequence s_w0; wrStrobe && regAddr == 6'h00; endsequence
  sequence s_w1; wrStrobe && regAddr == 6'h01; endsequence
  property p_sgl; s_w0 |-> ##2 singleDrive == $past(wrData[7], 2); endproperty
  a_sgl: assert property (p_sgl) else $error("single");
  property p_pair; s_w0 |-> ##2 altAntennaPairSelect == &$past(wrData[7:6], 2); endproperty
  a_pair: assert property (p_pair) else $error("pair");
  property p_xtal; s_w0 |-> ##2 xtalHighFreq == $past(wrData[3], 2); endproperty
  a_xtal: assert property (p_xtal) else $error("xtal");
  property p_hsel; s_w0 |-> ##2 hostClockSelect == $past(wrData[2:1], 2); endproperty
  a_hsel: assert property (p_hsel) else $error("hsel");
  // the pin may lag a code change, so only a steady code is judged
  property p_off; (hostClockSelect == 2'b11) [*4] |-> !hostClockOut; endproperty
  a_off: assert property (p_off) else $error("hclk off");
  property p_sup; s_w1 |-> ##2 lowSupplyMode == $past(wrData[7], 2); endproperty
  a_sup: assert property (p_sup) else $error("supply");
  property p_ramp; s_w1 |-> ##2 slowTxRamp == $past(wrData[0], 2); endproperty
  a_ramp: assert property (p_ramp) else $error("ramp");
  property p_rd; regAddr == 6'h01 |=> !rdData[5] && !rdData[1]; endproperty
  a_rd: assert property (p_rd) else $error("unused");
endmodule

bind io_configuration_registers io_config_props chk_u
(
  .ref_clk(ref_clk), .arst_n(arst_n), .wrStrobe(wrStrobe), .regAddr(regAddr), .wrData(wrData),
  .rdData(rdData), .singleDrive(singleDrive), .altAntennaPairSelect(altAntennaPairSelect),
  .xtalHighFreq(xtalHighFreq), .hostClockSelect(hostClockSelect), .hostClockOut(hostClockOut),
  .lowSupplyMode(lowSupplyMode), .slowTxRamp(slowTxRamp)
);

// File: tb/host_model.sv
// host model: register write and read cycles
`timescale 1ns/1ps
module host_model
(
  input logic ref_clk,
  input logic [7:0] rdData,
  output logic wrStrobe = 1'b0,
  output logic [5:0] regAddr = 6'h00,
  output logic [7:0] wrData = 8'h00
);
  // one-edge strobe; data scrambled after so a late sample shows
  task wr(input logic [5:0] a, input logic [7:0] v);
    regAddr = a;
    wrData = v;
    wrStrobe = 1'b1;
    @(posedge ref_clk);
    #1 wrStrobe = 1'b0;
    wrData = ~v;
    @(posedge ref_clk);
    #1;
  endtask
  // read data is registered, so it is taken one edge after the address
  task rd(input logic [5:0] a, output logic [7:0] v);
    regAddr = a;
    @(posedge ref_clk);
    #1 v = rdData;
  endtask
endmodule

// File: tb/io_configuration_registers_tb.sv
// testbench for the io configuration register bank
`timescale 1ns/1ps
module io_configuration_registers_tb;
  logic ref_clk = 0, arst_n = 0, oscRunning = 1, slowClock = 0, chipSelect_n = 1, serialOutDriven = 0;
  logic wrStrobe, singleDrive, altAntennaPairSelect, xtalHighFreq, hostClockOut, lowSupplyMode;
  logic digitalSupplyRailOff, serialOutPulldown, serialOutStrongDrive, slowTxRamp;
  logic [5:0] regAddr;
  logic [7:0] wrData, rdData, d;
  logic [6:0] rxWaterLevel, txWaterLevel;
  logic [1:0] hostClockSelect;
  localparam logic [7:0] V0 [4] = '{8'hc0, 8'h40, 8'h3e, 8'h91};
  int mismatches = 0, nTests = 0;
  always #4 ref_clk = ~ref_clk;
  // slow clock toggles every 8 ref cycles, off the ref edges
  initial #1 forever #64 slowClock = ~slowClock;
  host_model h (.ref_clk(ref_clk), .rdData(rdData), .wrStrobe(wrStrobe), .regAddr(regAddr), .wrData(wrData));
  io_configuration_registers dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .wrStrobe(wrStrobe),
    .regAddr(regAddr), .wrData(wrData), .rdData(rdData), .oscRunning(oscRunning), .slowClock(slowClock),
    .chipSelect_n(chipSelect_n), .serialOutDriven(serialOutDriven), .singleDrive(singleDrive),
    .altAntennaPairSelect(altAntennaPairSelect), .rxWaterLevel(rxWaterLevel), .txWaterLevel(txWaterLevel),
    .xtalHighFreq(xtalHighFreq), .hostClockSelect(hostClockSelect), .hostClockOut(hostClockOut),
    .lowSupplyMode(lowSupplyMode), .digitalSupplyRailOff(digitalSupplyRailOff),
    .serialOutPulldown(serialOutPulldown), .serialOutStrongDrive(serialOutStrongDrive), .slowTxRamp(slowTxRamp));
  task chk(input string n, input logic [7:0] e, g);
    nTests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task printVerdict;
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // count pin changes over 64 cycles once the code has settled
  task hc(input logic [7:0] v, input int e);
    int c;
    logic p;
    c = 0;
    h.wr(6'h00, v);
    repeat (4) @(posedge ref_clk);
    // step off the edge so the first reference value is the settled one
    #1;
    repeat (64)
    begin
      p = hostClockOut;
      @(posedge ref_clk);
      #1 c += int'(hostClockOut !== p);
    end
    chk("hclk", e[7:0], c[7:0]);
  endtask
  task pd(input logic [7:0] v, input logic cs, dr, e);
    h.wr(6'h01, v);
    chipSelect_n = cs;
    serialOutDriven = dr;
    repeat (5) @(posedge ref_clk);
    #1 chk("pulldown", e, serialOutPulldown);
  endtask
  initial
  begin
    #100000 mismatches++;
    printVerdict;
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1 arst_n = 1;
    h.rd(6'h00, d);
    chk("reg0", 8'h08, d);
    foreach (V0[i])
    begin
      h.wr(6'h00, V0[i]);
      h.rd(6'h00, d);
      chk("reg0", V0[i], d);
      chk("drive", {V0[i][7], &V0[i][7:6]}, {singleDrive, altAntennaPairSelect});
      chk("clock", {V0[i][3], V0[i][2:1]}, {xtalHighFreq, hostClockSelect});
      chk("rx", V0[i][5] ? 8'h50 : 8'h40, rxWaterLevel);
      chk("tx", V0[i][4] ? 8'h10 : 8'h20, txWaterLevel);
    end
    h.wr(6'h05, 8'hff);
    h.rd(6'h05, d);
    chk("unmapped", 8'h00, d);
    h.rd(6'h01, d);
    chk("reg1", 8'h00, d);
    h.wr(6'h01, 8'hff);
    h.rd(6'h01, d);
    chk("reg1", 8'hdd, d);
    chk("sup", 8'h0f, {lowSupplyMode, digitalSupplyRailOff, serialOutStrongDrive, slowTxRamp});
    hc(8'h00, 16);
    hc(8'h02, 32);
    hc(8'h04, 64);
    hc(8'h06, 0);
    oscRunning = 0;
    hc(8'h00, 8);
    hc(8'h01, 0);
    hc(8'h06, 0);
    pd(8'h08, 1, 0, 1);
    pd(8'h10, 1, 0, 0);
    pd(8'h10, 0, 0, 1);
    pd(8'h10, 0, 1, 0);
    pd(8'h08, 0, 0, 0);
    printVerdict;
  end
endmodule
